//--- touch_ctrl_regs.vh
// Register offsets, field positions, reset values and timing counts of the touch controller
`ifndef TOUCH_CTRL_REGS_VH
`define TOUCH_CTRL_REGS_VH
// ************************************************************
// Register offsets
// ************************************************************
`define TOUCH_MODE_REGISTER_ADDR 8'h08
`define CONVERTER_CONFIG_ADDR 8'h0a
`define TOUCH_IRQ_ADDR 8'h0b
`define CONV_CTRL_ADDR 8'h0c
`define CONV_RESULT_LO_ADDR 8'h0d
`define CONV_RESULT_HI_ADDR 8'h0e
// ************************************************************
// Field positions
// ************************************************************
`define CFG_CONV_EN_BIT 7
`define CFG_VREF_EN_BIT 6
`define IRQ_STATUS_BIT 0
`define IRQ_UNMASK_BIT 1
`define CTRL_START_BIT 0
`define CTRL_EOC_BIT 1
// ************************************************************
// Reset values and mode codes
// ************************************************************
`define TOUCH_MODE_RESET 3'h7
`define CFG_RESET 8'h00
`define MODE_XPOS 3'h0
`define MODE_YPOS 3'h1
`define MODE_PRESS 3'h2
`define MODE_XPLATE 3'h3
`define MODE_YPLATE 3'h4
`define MODE_STANDBY 3'h5
`define MODE_ADC 3'h6
`define MODE_OFF 3'h7
`define CH_TOUCH_A 4'he
`define CH_TOUCH_B 4'hf
// Terminal connections
`define TERM_OPEN 2'h0
`define TERM_REF 2'h1
`define TERM_GND 2'h2
`define TERM_ADC 2'h3
// ************************************************************
// Timing
// ************************************************************
`define CLK_MHZ 250
`define DEGLITCH_MS 8
`define DEGLITCH_CYCLES (`DEGLITCH_MS * 1000 * `CLK_MHZ)
`define SETTLE_CYCLES 16
`define ADC_BITS 10
`endif

//--- resistive_touch_controller.v
// Touch panel mode sequencer, switch matrix control and SAR converter sequencing
// Operation
// - Three-bit mode field in register 08h
// - Mode 111: terminals open, no touch
// - Mode 101: standby, X to reference, Y ground
// - Standby touch, 8 ms deglitch, unmasked low interrupt
// - Touch reference off in standby or off
// - Touch readings go to channels 14, 15
// - Ten-bit SAR result, fraction over 1024
// - Reference forced on when converter/touch enabled
// - Reference-enable bit keeps reference on otherwise
// - State machine sequences the switch matrix
// - Mode 010: pressure, X reference, Y ground
// - Mode 110: all terminals to converter
// - Mode 000: X position, sample Y
// - Mode 001: Y position, sample X
// - Status set on the write that changes the mode field, before the matrix settles; read clears
`include "touch_ctrl_regs.vh"
module resistive_touch_controller #(
    parameter DEGLITCH_CYCLES = `DEGLITCH_CYCLES,
    parameter SETTLE_CYCLES = `SETTLE_CYCLES,
    parameter ADC_BITS = `ADC_BITS
) (
    // Clock and reset
    input wire i_clk,
    input wire i_rstn,
    // Register port from the serial interface
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [7:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    output reg [7:0] o_reg_rdata,
    // Plate terminal sense and SAR comparator
    input wire i_x_plate_terminal_a_touch,
    input wire i_sar_cmp,
    // Switch matrix terminal connections
    output reg [1:0] o_x_plate_terminal_a,
    output reg [1:0] o_x_plate_terminal_b,
    output reg [1:0] o_y_plate_terminal_a,
    output reg [1:0] o_y_plate_terminal_b,
    output reg [3:0] o_touch_channel,
    // Supplies and converter
    output reg o_touch_reference_supply,
    output reg o_conv_reference_on,
    output reg [ADC_BITS-1:0] o_sar_dac,
    output reg o_sample,
    // Interrupt, active low
    output reg o_int_n
);
// ************************************************************
// States
// ************************************************************
localparam ST_IDLE = 2'h0;
localparam ST_SETTLE = 2'h1;
localparam ST_CONV = 2'h2;
reg [2:0] touch_mode_field_reg;
reg [7:0] cfg_reg;
reg touch_irq_status_reg;
reg touch_irq_unmask_reg;
reg eoc_reg;
reg [1:0] state_reg;
reg [15:0] settle_cnt_reg;
reg [31:0] deglitch_cnt_reg;
reg [ADC_BITS-1:0] result_reg;
reg [ADC_BITS-1:0] bit_reg;
reg start_pend_reg;
reg [2:0] applied_mode_reg;
reg [7:0] rdata_next;
wire conv_en = cfg_reg[`CFG_CONV_EN_BIT];
wire touch_en = (touch_mode_field_reg != `MODE_OFF);
wire wr_mode = i_reg_wr && (i_reg_addr == `TOUCH_MODE_REGISTER_ADDR);
wire wr_ctrl = i_reg_wr && (i_reg_addr == `CONV_CTRL_ADDR);
wire start_req = wr_ctrl && i_reg_wdata[`CTRL_START_BIT];
wire rd_irq = i_reg_rd && (i_reg_addr == `TOUCH_IRQ_ADDR);
wire wr_irq = i_reg_wr && (i_reg_addr == `TOUCH_IRQ_ADDR);
wire standby = (applied_mode_reg == `MODE_STANDBY);
wire touch_event = standby && i_x_plate_terminal_a_touch &&
    (deglitch_cnt_reg == DEGLITCH_CYCLES - 1);
wire set_status = touch_event || (wr_mode && i_reg_wdata[2:0] != touch_mode_field_reg);
// ************************************************************
// Register file
// ************************************************************
always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        touch_mode_field_reg <= `TOUCH_MODE_RESET;
        cfg_reg <= `CFG_RESET;
        touch_irq_unmask_reg <= 1'b0;
        touch_irq_status_reg <= 1'b0;
    end else begin
        if (wr_mode) begin
            touch_mode_field_reg <= i_reg_wdata[2:0];
        end else if (i_reg_wr && i_reg_addr == `CONVERTER_CONFIG_ADDR) begin
            cfg_reg <= i_reg_wdata;
        end
        if (wr_irq) begin
            touch_irq_unmask_reg <= i_reg_wdata[`IRQ_UNMASK_BIT];
        end
        if (set_status) begin
            touch_irq_status_reg <= 1'b1;
        end else if (rd_irq) begin
            touch_irq_status_reg <= 1'b0;
        end
    end
end
always @* begin
    rdata_next = 8'h00;
    if (i_reg_addr == `TOUCH_MODE_REGISTER_ADDR) begin
        rdata_next = {5'h00, touch_mode_field_reg};
    end else if (i_reg_addr == `CONVERTER_CONFIG_ADDR) begin
        rdata_next = cfg_reg;
    end else if (i_reg_addr == `TOUCH_IRQ_ADDR) begin
        rdata_next = {6'h00, touch_irq_unmask_reg, touch_irq_status_reg};
    end else if (i_reg_addr == `CONV_CTRL_ADDR) begin
        rdata_next = {6'h00, eoc_reg, start_pend_reg};
    end else if (i_reg_addr == `CONV_RESULT_LO_ADDR) begin
        rdata_next = result_reg[7:0];
    end else if (i_reg_addr == `CONV_RESULT_HI_ADDR) begin
        rdata_next = {6'h00, result_reg[ADC_BITS-1:8]};
    end
end
// ************************************************************
// Touch deglitch
// ************************************************************
always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        deglitch_cnt_reg <= 32'h00000000;
    end else if (!standby || !i_x_plate_terminal_a_touch) begin
        deglitch_cnt_reg <= 32'h00000000;
    end else if (deglitch_cnt_reg != DEGLITCH_CYCLES - 1) begin
        deglitch_cnt_reg <= deglitch_cnt_reg + 32'h00000001;
    end
end
// ************************************************************
// Sequencer and SAR
// ************************************************************
always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        state_reg <= ST_IDLE;
        applied_mode_reg <= `TOUCH_MODE_RESET;
        settle_cnt_reg <= 16'h0000;
        start_pend_reg <= 1'b0;
        eoc_reg <= 1'b0;
        result_reg <= {ADC_BITS{1'b0}};
        bit_reg <= {ADC_BITS{1'b0}};
        o_sar_dac <= {ADC_BITS{1'b0}};
        o_sample <= 1'b0;
    end else begin
        if (start_req) begin
            start_pend_reg <= 1'b1;
            eoc_reg <= 1'b0;
        end
        o_sample <= 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (applied_mode_reg != touch_mode_field_reg) begin
                    applied_mode_reg <= touch_mode_field_reg;
                    settle_cnt_reg <= SETTLE_CYCLES[15:0];
                    state_reg <= ST_SETTLE;
                end else if (start_pend_reg && conv_en) begin
                    start_pend_reg <= start_req;
                    o_sample <= 1'b1;
                    bit_reg <= {1'b1, {(ADC_BITS-1){1'b0}}};
                    o_sar_dac <= {1'b1, {(ADC_BITS-1){1'b0}}};
                    state_reg <= ST_CONV;
                end
            end
            ST_SETTLE: begin
                if (settle_cnt_reg == 16'h0000) begin
                    state_reg <= ST_IDLE;
                end else begin
                    settle_cnt_reg <= settle_cnt_reg - 16'h0001;
                end
            end
            default: begin
                if (bit_reg == {ADC_BITS{1'b0}}) begin
                    result_reg <= o_sar_dac;
                    eoc_reg <= 1'b1;
                    state_reg <= ST_IDLE;
                end else begin
                    if (!i_sar_cmp) begin
                        o_sar_dac <= (o_sar_dac & ~bit_reg) | (bit_reg >> 1);
                    end else begin
                        o_sar_dac <= o_sar_dac | (bit_reg >> 1);
                    end
                    bit_reg <= bit_reg >> 1;
                end
            end
        endcase
    end
end
// ************************************************************
// Switch matrix and outputs
// ************************************************************
always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        o_x_plate_terminal_a <= `TERM_OPEN;
        o_x_plate_terminal_b <= `TERM_OPEN;
        o_y_plate_terminal_a <= `TERM_OPEN;
        o_y_plate_terminal_b <= `TERM_OPEN;
        o_touch_channel <= `CH_TOUCH_A;
        o_touch_reference_supply <= 1'b0;
        o_conv_reference_on <= 1'b0;
        o_reg_rdata <= 8'h00;
        o_int_n <= 1'b1;
    end else begin
        o_reg_rdata <= rdata_next;
        o_int_n <= !(touch_irq_status_reg && touch_irq_unmask_reg);
        o_touch_reference_supply <= !standby && (applied_mode_reg != `MODE_OFF);
        o_conv_reference_on <= conv_en || touch_en || cfg_reg[`CFG_VREF_EN_BIT];
        o_touch_channel <= `CH_TOUCH_A;
        case (applied_mode_reg)
            `MODE_XPOS: begin
                o_x_plate_terminal_a <= `TERM_REF;
                o_x_plate_terminal_b <= `TERM_GND;
                o_y_plate_terminal_a <= `TERM_ADC;
                o_y_plate_terminal_b <= `TERM_ADC;
            end
            `MODE_YPOS: begin
                o_x_plate_terminal_a <= `TERM_ADC;
                o_x_plate_terminal_b <= `TERM_ADC;
                o_y_plate_terminal_a <= `TERM_REF;
                o_y_plate_terminal_b <= `TERM_GND;
            end
            `MODE_PRESS, `MODE_STANDBY: begin
                o_x_plate_terminal_a <= `TERM_REF;
                o_x_plate_terminal_b <= `TERM_REF;
                o_y_plate_terminal_a <= `TERM_GND;
                o_y_plate_terminal_b <= `TERM_GND;
                if (applied_mode_reg == `MODE_PRESS) begin
                    o_touch_channel <= `CH_TOUCH_B;
                end
            end
            `MODE_XPLATE: begin
                o_x_plate_terminal_a <= `TERM_REF;
                o_x_plate_terminal_b <= `TERM_GND;
                o_y_plate_terminal_a <= `TERM_OPEN;
                o_y_plate_terminal_b <= `TERM_OPEN;
            end
            `MODE_YPLATE: begin
                o_x_plate_terminal_a <= `TERM_OPEN;
                o_x_plate_terminal_b <= `TERM_OPEN;
                o_y_plate_terminal_a <= `TERM_REF;
                o_y_plate_terminal_b <= `TERM_GND;
            end
            `MODE_ADC: begin
                o_x_plate_terminal_a <= `TERM_ADC;
                o_x_plate_terminal_b <= `TERM_ADC;
                o_y_plate_terminal_a <= `TERM_ADC;
                o_y_plate_terminal_b <= `TERM_ADC;
            end
            default: begin
                o_x_plate_terminal_a <= `TERM_OPEN;
                o_x_plate_terminal_b <= `TERM_OPEN;
                o_y_plate_terminal_a <= `TERM_OPEN;
                o_y_plate_terminal_b <= `TERM_OPEN;
            end
        endcase
    end
end
endmodule

//--- touch_ctrl_properties.sv
// Concurrent checks on the touch controller ports
`include "touch_ctrl_regs.vh"
module touch_ctrl_checker #(
    parameter int SETTLE_CYCLES = 16
) (
    // Clock and reset
    input wire i_clk,
    input wire i_rstn,
    // Register writes
    input wire i_reg_wr,
    input wire [7:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    // Observed outputs
    input wire [1:0] o_x_plate_terminal_a,
    input wire [1:0] o_x_plate_terminal_b,
    input wire [1:0] o_y_plate_terminal_a,
    input wire [1:0] o_y_plate_terminal_b,
    input wire o_touch_reference_supply,
    input wire o_conv_reference_on,
    input wire o_sample
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] mode_reg;
    logic [7:0] age_reg;
    logic [7:0] term;
    logic settled;
    assign term = {o_x_plate_terminal_a, o_x_plate_terminal_b, o_y_plate_terminal_a,
                   o_y_plate_terminal_b};
    assign settled = (age_reg > 8'h18);
    // ************************************************************
    // Shadow of the mode field and cycles since it last changed
    // ************************************************************
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mode_reg <= `MODE_OFF;
            age_reg <= 8'h00;
        end else if (i_reg_wr && (i_reg_addr == `TOUCH_MODE_REGISTER_ADDR) &&
                     (i_reg_wdata[2:0] != mode_reg)) begin
            mode_reg <= i_reg_wdata[2:0];
            age_reg <= 8'h00;
        end else if (age_reg != 8'hff) begin
            age_reg <= age_reg + 8'h01;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    a_off_open: assert property (settled && mode_reg == `MODE_OFF |-> term == 8'h00)
        else $error("terminals not open in off mode");
    a_standby_map: assert property (settled && mode_reg == `MODE_STANDBY |-> term == 8'h5a)
        else $error("standby switch map wrong");
    a_press_map: assert property (settled && mode_reg == `MODE_PRESS |-> term == 8'h5a)
        else $error("pressure switch map wrong");
    a_xpos_map: assert property (settled && mode_reg == `MODE_XPOS |-> term == 8'h6f)
        else $error("x position switch map wrong");
    a_ypos_map: assert property (settled && mode_reg == `MODE_YPOS |-> term == 8'hf6)
        else $error("y position switch map wrong");
    a_plate_map: assert property (settled && (mode_reg == 3'h3 || mode_reg == 3'h4)
        |-> term == ((mode_reg == `MODE_XPLATE) ? 8'h60 : 8'h06)) else $error("plate map wrong");
    a_adc_map: assert property (settled && mode_reg == `MODE_ADC |-> term == 8'hff)
        else $error("converter switch map wrong");
    a_tref_off: assert property (settled && mode_reg[2] && mode_reg[0]
        |-> !o_touch_reference_supply) else $error("touch reference on in standby or off");
    a_conv_ref: assert property (settled && mode_reg != `MODE_OFF |-> o_conv_reference_on)
        else $error("converter reference not forced on");
    a_sample_wait: assert property (o_sample |-> age_reg > SETTLE_CYCLES)
        else $error("conversion started before matrix settled");
endmodule
bind resistive_touch_controller touch_ctrl_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_checker (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_x_plate_terminal_a(o_x_plate_terminal_a),
    .o_x_plate_terminal_b(o_x_plate_terminal_b), .o_y_plate_terminal_a(o_y_plate_terminal_a),
    .o_y_plate_terminal_b(o_y_plate_terminal_b), .o_sample(o_sample),
    .o_touch_reference_supply(o_touch_reference_supply), .o_conv_reference_on(o_conv_reference_on)
);

//--- touch_panel_model.sv
// Behavioural four-wire panel and plate voltage comparator
module touch_panel_model (
    // Switch matrix and converter trial code
    input wire logic [1:0] i_x_plate_terminal_a,
    input wire logic [9:0] i_sar_dac,
    // Scenario control
    input wire logic i_touched,
    input wire logic [9:0] i_level,
    // Sense lines back to the controller
    output logic o_touch,
    output logic o_sar_cmp
);
    timeunit 1ns;
    timeprecision 1ps;
    // A press only moves terminal a when it is pulled to the reference
    assign o_touch = i_touched && (i_x_plate_terminal_a == 2'h1);
    // Keep the trial bit while the plate voltage is at or above it
    assign o_sar_cmp = (i_level >= i_sar_dac);
endmodule

//--- testbench.sv
// Self-checking bench for the touch controller with a panel model
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk, i_rstn, i_reg_wr, i_reg_rd, touched, rd_d, tref, cref, smp, int_n, tch, cmp;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
    logic [1:0] xa, xb, ya, yb;
    logic [3:0] chan;
    logic [9:0] level, dac;
    logic [7:0] exp_q[$];
    logic [31:0] seed;
    int n_mismatch, check_count, cyc;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic check(input string what, input logic [9:0] e, input logic [9:0] g);
        check_count++;
        if (e !== g) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cycles(1);
        i_reg_wr = 1'b1;
        i_reg_addr = a;
        i_reg_wdata = d;
        cycles(1);
        i_reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        cycles(1);
        i_reg_rd = 1'b1;
        i_reg_addr = a;
        exp_q.push_back(e);
        cycles(1);
        i_reg_rd = 1'b0;
    endtask
    task automatic conclude();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    resistive_touch_controller #(.DEGLITCH_CYCLES(20)) dut (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
        .i_x_plate_terminal_a_touch(tch), .i_sar_cmp(cmp), .o_x_plate_terminal_a(xa),
        .o_x_plate_terminal_b(xb), .o_y_plate_terminal_a(ya), .o_y_plate_terminal_b(yb),
        .o_touch_channel(chan), .o_touch_reference_supply(tref), .o_conv_reference_on(cref),
        .o_sar_dac(dac), .o_sample(smp), .o_int_n(int_n));
    touch_panel_model panel (.i_x_plate_terminal_a(xa), .i_sar_dac(dac), .i_touched(touched),
        .i_level(level), .o_touch(tch), .o_sar_cmp(cmp));
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    // ************************************************************
    // Read result monitor and run limit
    // ************************************************************
    always @(posedge i_clk) begin
        if (rd_d) check("rdata", {2'b00, exp_q.pop_front()}, {2'b00, o_reg_rdata});
        rd_d <= i_reg_rd;
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            conclude();
        end
    end
    initial begin
        {i_rstn, i_reg_wr, i_reg_rd, touched} = 4'h0;
        {i_reg_addr, i_reg_wdata, level} = 26'h0;
        seed = 32'h63;
        cycles(8);
        i_rstn = 1'b1;
        rd(8'h08, 8'h07);
        rd(8'h20, 8'h00);
        for (int m = 0; m < 8; m++) begin
            wr(8'h08, 8'(m));
            cycles(30);
            check("channel", (m == 2) ? 10'h00f : 10'h00e, 10'(chan));
            check("touch ref", (m == 5 || m == 7) ? 10'h000 : 10'h001, 10'(tref));
            rd(8'h08, 8'(m));
        end
        wr(8'h0a, 8'h00);
        cycles(4);
        check("conv ref", 10'h000, 10'(cref));
        wr(8'h0a, 8'h40);
        cycles(4);
        check("conv ref", 10'h001, 10'(cref));
        wr(8'h08, 8'h05);
        cycles(30);
        rd(8'h0b, 8'h01);
        touched = 1'b1;
        cycles(27);
        check("irq masked", 10'h001, 10'(int_n));
        touched = 1'b0;
        wr(8'h0b, 8'h02);
        for (int m = 5; m > 1; m = m - 3) begin
            wr(8'h08, 8'(m));
            cycles(30);
            rd(8'h0b, 8'h03);
            touched = 1'b1;
            cycles(15);
            check("irq early", 10'h001, 10'(int_n));
            cycles(12);
            check("irq", (m == 5) ? 10'h000 : 10'h001, 10'(int_n));
            touched = 1'b0;
            rd(8'h0b, (m == 5) ? 8'h03 : 8'h02);
            cycles(3);
            check("irq clear", 10'h001, 10'(int_n));
        end
        wr(8'h0a, 8'h80);
        for (int m = 0; m < 3; m++) begin
            seed = xs(seed);
            level = seed[9:0];
            wr(8'h08, 8'(m));
            wr(8'h0c, 8'h01);
            for (int k = 0; k < 100 && !smp; k++) cycles(1);
            check("sample", 10'h001, 10'(smp));
            cycles(20);
            rd(8'h0c, 8'h02);
            rd(8'h0d, level[7:0]);
            rd(8'h0e, {6'h00, level[9:8]});
        end
        cycles(4);
        conclude();
    end
endmodule
